// ===== dv/evr_mem_model.sv
// vector table memory and stack push partner of the exception unit
`timescale 1ns/1ps

module evr_mem_model (
	input  wire logic        clk_i,        // system clock
	input  wire logic        rst_i,        // sync reset, active high
	input  wire logic        fetch_req_i,  // vector read request
	input  wire logic [31:0] fetch_addr_i, // vector read address
	output logic             fetch_ack_o,  // read done pulse
	output logic      [31:0] fetch_data_o, // read data
	input  wire logic        save_req_i,   // push request
	output logic             save_ack_o,   // push done pulse
	input  wire logic [1:0]  dly_i         // extra wait cycles per answer
);
	logic [31:0] word_q;
	logic [1:0]  cnt_q;
	logic        cool_q;

	////////////////////////////////////////////////////////////////////////////////
	// released bus shows the inverse of the last word, so a late sample never matches
	assign fetch_data_o = fetch_ack_o ? word_q : ~word_q;

	// one cycle of rest after each answer lets the requester move its address
	always_ff @(posedge clk_i) begin
		fetch_ack_o <= 1'b0;
		save_ack_o  <= 1'b0;
		cool_q      <= fetch_ack_o | save_ack_o;
		if (rst_i) begin
			cnt_q  <= 2'h0;
			word_q <= 32'h0;
		end else if ((fetch_req_i | save_req_i) & ~fetch_ack_o & ~save_ack_o & ~cool_q) begin
			if (cnt_q == dly_i) begin
				cnt_q       <= 2'h0;
				fetch_ack_o <= fetch_req_i;
				save_ack_o  <= save_req_i & ~fetch_req_i;
				word_q      <= fetch_req_i ? (32'h0800_0000 | (fetch_addr_i * 32'h11)) : word_q;
			end else begin
				cnt_q <= cnt_q + 2'h1;
			end
		end
	end
endmodule : evr_mem_model

// ===== dv/exception_vector_reset_unit_bench.sv
// self-checking bench of the exception vector and reset unit
`timescale 1ns/1ps

module exception_vector_reset_unit_bench;
	logic               clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic               cold_reset_n_pin_i = 1'b1, warm_reset_n_pin_i = 1'b1, bus_busy_i = 1'b0, exc_valid_i = 1'b0;
	logic [7:0]         wb_adr_i = 8'h00, exc_num_i = 8'h00;
	logic [3:0]         wb_sel_i = 4'h0, exc_level_i = 4'h0, mask_o, m_exp;
	logic [31:0]        wb_dat_i = 32'h0, wb_dat_o, fetch_addr_o, fetch_data_i, pc_o, sp_o, vector_base_o, base_exp;
	logic               wb_ack_o, exc_ack_o, exc_rej_o, save_req_o, save_ack_i, fetch_req_o, fetch_ack_i;
	logic               jump_o, sp_load_o, cpu_rst_o, per_rst_o;
	logic [1:0]         dly = 2'h0;
	evr_pkg::exc_kind_t exc_kind_i = evr_pkg::EXC_ILL_GEN;
	logic [31:0]        expq [$];
	int                 vtab [0:5] = '{4, 6, 9, 10, 11, 12};
	int                 num_errors = 0, n_tests = 0, saves = 0;

	exception_vector_reset_unit dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cold_reset_n_pin_i(cold_reset_n_pin_i), .warm_reset_n_pin_i(warm_reset_n_pin_i),
		.bus_busy_i(bus_busy_i), .exc_valid_i(exc_valid_i), .exc_kind_i(exc_kind_i), .exc_num_i(exc_num_i),
		.exc_level_i(exc_level_i), .exc_ack_o(exc_ack_o), .exc_rej_o(exc_rej_o), .save_req_o(save_req_o),
		.save_ack_i(save_ack_i), .fetch_req_o(fetch_req_o), .fetch_addr_o(fetch_addr_o),
		.fetch_ack_i(fetch_ack_i), .fetch_data_i(fetch_data_i), .pc_o(pc_o), .sp_o(sp_o), .jump_o(jump_o),
		.sp_load_o(sp_load_o), .mask_o(mask_o), .vector_base_o(vector_base_o), .cpu_rst_o(cpu_rst_o),
		.per_rst_o(per_rst_o));
	evr_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o),
		.fetch_ack_o(fetch_ack_i), .fetch_data_o(fetch_data_i), .save_req_i(save_req_o), .save_ack_o(save_ack_i),
		.dly_i(dly));

	always #5 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] tbl(input logic [31:0] a);
		return 32'h0800_0000 | (a * 32'h11);
	endfunction : tbl

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run

	// results come in a fixed order, so one queue of notes serves every output
	always @(posedge clk_i) if (!rst_i) begin
		if (exc_ack_o | exc_rej_o) check({31'h0, exc_rej_o}, expq.pop_front());
		if (fetch_ack_i & fetch_req_o) check(fetch_addr_o, expq.pop_front());
		if (jump_o) check(pc_o, expq.pop_front());
		if (sp_load_o) begin
			check(sp_o, expq.pop_front());
			check({28'h0, mask_o}, expq.pop_front());
			check(vector_base_o, expq.pop_front());
		end
		if (wb_ack_o & !wb_we_i) check(wb_dat_o, expq.pop_front());
		if (save_ack_i & save_req_o) saves++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		{wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= s;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		{wb_cyc_i, wb_stb_i} <= 2'b00;
		@(posedge clk_i);
	endtask : wb

	task automatic pulse(input logic cold, input int n);
		if (cold)
			cold_reset_n_pin_i <= 1'b0;
		else
			warm_reset_n_pin_i <= 1'b0;
		repeat (n) @(posedge clk_i);
		check({31'h0, cpu_rst_o}, 32'h1);
		check({31'h0, per_rst_o}, {31'h0, cold});
		{cold_reset_n_pin_i, warm_reset_n_pin_i} <= 2'b11;
	endtask : pulse

	task automatic exp_reset(input logic [31:0] a);
		expq.push_back(a);
		expq.push_back(a + 32'h4);
		expq.push_back(tbl(a));
		expq.push_back(tbl(a + 32'h4));
		expq.push_back(32'hf);
		expq.push_back(32'h0);
		m_exp = 4'hf;
		base_exp = 32'h0;
	endtask : exp_reset

	task automatic exc(input int k, input logic [7:0] n, input logic [7:0] v, input logic rej);
		logic [3:0] l;
		int s;
		l = 4'($urandom);
		exc_valid_i <= 1'b1;
		exc_kind_i <= evr_pkg::exc_kind_t'(k);
		exc_num_i <= n;
		exc_level_i <= l;
		dly <= 2'($urandom);
		expq.push_back({31'h0, rej});
		if (!rej) begin
			expq.push_back(base_exp + {22'h0, v, 2'h0});
			expq.push_back(tbl(base_exp + {22'h0, v, 2'h0}));
		end
		do @(posedge clk_i); while (!(exc_ack_o | exc_rej_o));
		exc_valid_i <= 1'b0;
		s = saves;
		if (!rej) begin
			do @(posedge clk_i); while (jump_o !== 1'b1);
			if (k == 4)
				m_exp = 4'hf;
			else if (k >= 5 && k <= 7)
				m_exp = l;
			@(posedge clk_i);
			check({28'h0, mask_o}, {28'h0, m_exp});
			check(saves - s, 1);
		end
		@(posedge clk_i);
	endtask : exc

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] b;
		int n, v;
		void'($urandom(25992));
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		pulse(1'b1, 10);
		repeat (30) @(posedge clk_i);
		check({30'h0, cpu_rst_o, fetch_req_o}, 32'h2);
		pulse(1'b1, 21);
		exp_reset(32'h0);
		// request waiting through the reset fetches
		exc(0, 8'h00, 8'h04, 1'b0);
		b = $urandom;
		wb(1'b1, 8'h00, b, 4'hf);
		base_exp = b & 32'hffff_fffc;
		wb(1'b1, 8'h00, ~b, 4'h2);
		base_exp[15:8] = ~b[15:8];
		expq.push_back(base_exp);
		wb(1'b0, 8'h00, 32'h0, 4'hf);
		expq.push_back(32'h0);
		wb(1'b0, 8'h2c, 32'h0, 4'hf);
		wb(1'b1, 8'h0c, b, 4'hf);
		expq.push_back(tbl(32'h10));
		wb(1'b0, 8'h0c, 32'h0, 4'hf);
		wb(1'b1, 8'h04, 32'h3, 4'h1);
		m_exp = 4'h3;
		// 735 lands on the top line, trap and peripheral numbers at once
		for (int p = 0; p < 3; p++)
			for (int k = 0; k < 9; k++) begin
				n = (p == 2) ? $urandom_range(0, 4095) : (p == 1) ? 735 : 0;
				case (k)
					6: begin n = n % 8; v = 64 + n; end
					7: begin n = 72 + n % 184; v = n; end
					8: begin n = 32 + n % 32; v = n; end
					default: v = vtab[k];
				endcase
				exc(k, 8'(n), 8'(v), 1'b0);
			end
		exc(8, 8'h1f, 8'h00, 1'b1);
		exc(8, 8'h40, 8'h00, 1'b1);
		exc(6, 8'h08, 8'h00, 1'b1);
		exc(7, 8'h47, 8'h00, 1'b1);
		bus_busy_i <= 1'b1;
		warm_reset_n_pin_i <= 1'b0;
		repeat (25) @(posedge clk_i);
		check({31'h0, cpu_rst_o}, 32'h0);
		bus_busy_i <= 1'b0;
		pulse(1'b0, 24);
		exp_reset(32'h8);
		do @(posedge clk_i); while (jump_o !== 1'b1);
		@(posedge clk_i);
		expq.push_back(32'h0);
		wb(1'b0, 8'h00, 32'h0, 4'hf);
		expq.push_back(32'hf);
		wb(1'b0, 8'h04, 32'h0, 4'hf);
		exc(4, 8'h00, 8'h0b, 1'b0);
		repeat (5) @(posedge clk_i);
		check(expq.size(), 0);
		complete_run();
	end

	// whole run is near 600 cycles; 10000 means a hang
	initial begin
		#100000;
		num_errors++;
		complete_run();
	end
endmodule : exception_vector_reset_unit_bench

// ===== hdl/evr_pin_sync.sv
// two-flop synchroniser for the two reset pins
`timescale 1ns/1ps
`include "evr_regs.svh"

module evr_pin_sync (
	input  wire logic       clk_i,   // system clock
	input  wire logic       rst_i,   // sync reset, active high
	input  wire logic [1:0] pins_i,  // raw pins
	output logic      [1:0] pins_o   // synchronised pins
);

	evr_pkg::sync_t q, d;

	always_comb begin
		d = q;
		for (int i = 0; i < 2; i++) begin
			d.s1[i] = pins_i[i];
			d.s2[i] = q.s1[i];
		end
	end

	// pins idle high, so reset must not fake an asserted reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q.s1 <= `PIN_IDLE;
			q.s2 <= `PIN_IDLE;
		end else begin
			q <= d;
		end
	end

	assign pins_o = q.s2;

endmodule : evr_pin_sync

// ===== hdl/evr_vec_addr.sv
// vector table address from vector number and base
`timescale 1ns/1ps

module evr_vec_addr (
	input  wire logic        reset_i,  // reset vector: no base
	input  wire logic [31:0] base_i,   // vector base
	input  wire logic [7:0]  num_i,    // vector number
	output logic      [31:0] addr_o    // table address
);

	logic [31:0] offs;

	assign offs   = {22'h0, num_i, 2'h0};
	assign addr_o = reset_i ? offs : base_i + offs;

endmodule : evr_vec_addr

// ===== hdl/exception_vector_reset_unit.sv
// exception vector addressing and cold/warm reset sequencing
// Overview of operation
// - reset vector fetch address is vector number times four, no base
// - other exceptions fetch at vector base plus vector number times four
// - illegal instruction 4, slot illegal 6, processor address error 9
// - transfer address error 10, non-maskable interrupt 11, user break 12
// - trap vectors occupy numbers 32 to 63
// - interrupt lines 0 to 7 map to vectors 64 to 71
// - peripheral interrupts use vectors 72 to 255, numbers given by controller
// - resets outrank every other exception source
// - cold pin low resets processor state and all peripheral registers
// - warm pin low with cold high resets processor only
// - cold reset processing starts only on release after the full hold
// - reset entry first fetches initial program counter from vector 0
// - then fetches initial stack pointer from vector 1
// - reset entry clears vector base and sets mask bits to all ones
// - load fetched counter and stack pointer, then run from the counter
// - warm release starts the same sequence using vectors 2 and 3
// - warm reset waits for a running bus cycle to end
// - bus controller is untouched by warm reset
// - non-reset exceptions save status and counter before the vector fetch
`timescale 1ns/1ps
`include "evr_regs.svh"

module exception_vector_reset_unit (
	input  wire logic                clk_i,              // system clock
	input  wire logic                rst_i,              // sync reset, active high
	input  wire logic                wb_cyc_i,           // wishbone cycle
	input  wire logic                wb_stb_i,           // wishbone strobe
	input  wire logic                wb_we_i,            // wishbone write
	input  wire logic [7:0]          wb_adr_i,           // wishbone byte address
	input  wire logic [3:0]          wb_sel_i,           // wishbone byte lanes
	input  wire logic [31:0]         wb_dat_i,           // wishbone write data
	output logic      [31:0]         wb_dat_o,           // wishbone read data
	output logic                     wb_ack_o,           // wishbone ack
	input  wire logic                cold_reset_n_pin_i, // cold reset pin
	input  wire logic                warm_reset_n_pin_i, // warm reset pin
	input  wire logic                bus_busy_i,         // external bus cycle running
	input  wire logic                exc_valid_i,        // exception request
	input  evr_pkg::exc_kind_t       exc_kind_i,         // exception kind
	input  wire logic [7:0]          exc_num_i,          // line, trap or peripheral number
	input  wire logic [3:0]          exc_level_i,        // accepted interrupt level
	output logic                     exc_ack_o,          // request taken
	output logic                     exc_rej_o,          // request refused
	output logic                     save_req_o,         // push status and counter
	input  wire logic                save_ack_i,         // push done
	output logic                     fetch_req_o,        // vector read request
	output logic      [31:0]         fetch_addr_o,       // vector read address
	input  wire logic                fetch_ack_i,        // vector read done
	input  wire logic [31:0]         fetch_data_i,       // vector read data
	output logic      [31:0]         pc_o,               // fetched counter
	output logic      [31:0]         sp_o,               // fetched stack pointer
	output logic                     jump_o,             // start at pc_o
	output logic                     sp_load_o,          // load sp_o
	output logic      [3:0]          mask_o,             // interrupt mask level
	output logic      [31:0]         vector_base_o,      // vector base
	output logic                     cpu_rst_o,          // processor held in reset
	output logic                     per_rst_o           // peripherals held in reset
);

	////////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	function automatic logic vec_reserved(input logic [7:0] v);
		vec_reserved = (v == `VEC_RSVD_A) || (v == `VEC_RSVD_B) || (v == `VEC_RSVD_C) ||
			(v >= `VEC_SYS_LO && v <= `VEC_SYS_HI);
	endfunction : vec_reserved

	function automatic logic [7:0] vec_of(input evr_pkg::exc_kind_t k, input logic [7:0] n);
		unique case (k)
			evr_pkg::EXC_ILL_GEN:  vec_of = `VEC_ILL_GEN;
			evr_pkg::EXC_ILL_SLOT: vec_of = `VEC_ILL_SLOT;
			evr_pkg::EXC_CPU_AERR: vec_of = `VEC_CPU_AERR;
			evr_pkg::EXC_XFR_AERR: vec_of = `VEC_XFER_AERR;
			evr_pkg::EXC_NMI:      vec_of = `VEC_NMI;
			evr_pkg::EXC_UBRK:     vec_of = `VEC_UBRK;
			evr_pkg::EXC_IRQ:      vec_of = `VEC_IRQ_BASE + {5'h0, n[2:0]};
			evr_pkg::EXC_PERIPH:   vec_of = n;
			evr_pkg::EXC_TRAP:     vec_of = n;
			default:               vec_of = `VEC_RSVD_A;
		endcase
	endfunction : vec_of

	// out-of-range numbers are refused rather than folded into a legal vector
	function automatic logic exc_legal(input evr_pkg::exc_kind_t k, input logic [7:0] n);
		logic ok;
		ok = 1'b1;
		if (k == evr_pkg::EXC_IRQ && n > `IRQ_LINE_MAX)
			ok = 1'b0;
		if (k == evr_pkg::EXC_TRAP && (n < `VEC_TRAP_LO || n > `VEC_TRAP_HI))
			ok = 1'b0;
		if (k == evr_pkg::EXC_PERIPH && n < `VEC_PERIPH_LO)
			ok = 1'b0;
		exc_legal = ok && !vec_reserved(vec_of(k, n));
	endfunction : exc_legal

	function automatic logic is_intr(input evr_pkg::exc_kind_t k);
		is_intr = (k == evr_pkg::EXC_NMI) || (k == evr_pkg::EXC_UBRK) ||
			(k == evr_pkg::EXC_IRQ) || (k == evr_pkg::EXC_PERIPH);
	endfunction : is_intr

	////////////////////////////////////////////////////////////////////////////////
	// pins and address calculation

	evr_pkg::ctl_t q, d;
	logic [1:0]    pins_s;
	logic          cold_s;
	logic          warm_s;
	logic          calc_rst;
	logic [7:0]    calc_vec;
	logic [31:0]   calc_addr;
	logic          wb_req;
	logic          busy;

	evr_pin_sync u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pins_i ({warm_reset_n_pin_i, cold_reset_n_pin_i}),
		.pins_o (pins_s)
	);

	assign cold_s = pins_s[0];
	assign warm_s = pins_s[1];
	// address source follows the state so the adder never sees its own result
	always_comb begin
		calc_rst = 1'b1;
		calc_vec = q.warm ? `VEC_WARM_PC : `VEC_COLD_PC;
		unique case (q.st)
			evr_pkg::ST_RESET: calc_rst = 1'b1;
			evr_pkg::ST_FPC:   calc_vec = q.vec + 8'h1;
			evr_pkg::ST_FSP:   calc_vec = q.vec;
			evr_pkg::ST_RUN, evr_pkg::ST_SAVE, evr_pkg::ST_FVEC: begin
				calc_rst = 1'b0;
				calc_vec = q.vec;
			end
		endcase
	end

	evr_vec_addr u_addr (
		.reset_i (calc_rst),
		.base_i  (q.vbase),
		.num_i   (calc_vec),
		.addr_o  (calc_addr)
	);
	assign wb_req = wb_cyc_i && wb_stb_i && !q.wb_ack;
	// our own vector reads and pushes count as bus cycles too
	assign busy   = bus_busy_i || q.fetch_req || q.save_req;
	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		d         = q;
		d.jump    = 1'b0;
		d.sp_load = 1'b0;
		d.exc_ack = 1'b0;
		d.exc_rej = 1'b0;
		d.wb_ack  = 1'b0;
		if (wb_req) begin
			d.wb_ack = 1'b1;
			d.wb_dat = 32'h0;
			if (wb_we_i) begin
				if (wb_adr_i == `OFF_VECTOR_BASE) begin
					for (int i = 0; i < 4; i++) begin
						if (wb_sel_i[i])
							d.vbase[8*i +: 8] = wb_dat_i[8*i +: 8];
					end
					d.vbase[1:0] = 2'h0;
				end
				if (wb_adr_i == `OFF_STATUS_WORD && wb_sel_i[0])
					d.mask = wb_dat_i[3:0];
			end else begin
				unique case (wb_adr_i)
					`OFF_VECTOR_BASE: d.wb_dat = q.vbase;
					`OFF_STATUS_WORD: d.wb_dat = {28'h0, q.mask};
					`OFF_UNIT_STATE:  d.wb_dat = {17'h0, q.warm, q.st, q.vec};
					`OFF_INIT_PC:     d.wb_dat = q.pc;
					`OFF_INIT_SP:     d.wb_dat = q.sp;
					default:          d.wb_dat = 32'h0;
				endcase
			end
		end
		// hold counter runs while either pin is low
		if (!cold_s || !warm_s) begin
			if (q.cnt != `RESET_HOLD_CYC)
				d.cnt = q.cnt + 5'h1;
		end else begin
			d.cnt = 5'h0;
		end
		if (!cold_s) begin
			// cold pin wins over everything else
			d.st        = evr_pkg::ST_RESET;
			d.cpu_rst   = 1'b1;
			d.per_rst   = 1'b1;
			d.warm      = 1'b0;
			d.fetch_req = 1'b0;
			d.save_req  = 1'b0;
		end else if (!warm_s && q.st != evr_pkg::ST_RESET && !busy) begin
			// peripherals and the bus controller keep running
			d.st        = evr_pkg::ST_RESET;
			d.cpu_rst   = 1'b1;
			d.warm      = 1'b1;
		end else begin
			// a running fetch or push still completes while warm reset waits
			unique case (q.st)
				evr_pkg::ST_RESET: begin
					if (cold_s && warm_s) begin
						// a short pulse leaves the processor parked in reset
						if (q.cnt == `RESET_HOLD_CYC) begin
							d.st         = evr_pkg::ST_FPC;
							d.per_rst    = 1'b0;
							d.vec        = calc_vec;
							d.fetch_addr = calc_addr;
							d.fetch_req  = 1'b1;
						end
					end
				end
				evr_pkg::ST_FPC: begin
					if (fetch_ack_i) begin
						d.pc         = fetch_data_i;
						d.vec        = calc_vec;
						d.fetch_addr = calc_addr;
						d.st         = evr_pkg::ST_FSP;
					end
				end
				evr_pkg::ST_FSP: begin
					if (fetch_ack_i) begin
						d.sp        = fetch_data_i;
						d.fetch_req = 1'b0;
						d.vbase     = `VBASE_RESET;
						d.mask      = `MASK_ALL_ONES;
						d.cpu_rst   = 1'b0;
						d.jump      = 1'b1;
						d.sp_load   = 1'b1;
						d.st        = evr_pkg::ST_RUN;
					end
				end
				evr_pkg::ST_RUN: begin
					if (exc_valid_i && warm_s && !q.exc_rej) begin
						if (exc_legal(exc_kind_i, exc_num_i)) begin
							d.exc_ack  = 1'b1;
							d.vec      = vec_of(exc_kind_i, exc_num_i);
							d.save_req = 1'b1;
							d.st       = evr_pkg::ST_SAVE;
							d.pmask    = q.mask;
							if (is_intr(exc_kind_i))
								d.pmask = (exc_kind_i == evr_pkg::EXC_NMI) ? `MASK_ALL_ONES : exc_level_i;
						end else begin
							d.exc_rej = 1'b1;
						end
					end
				end
				evr_pkg::ST_SAVE: begin
					// mask changes only after the old status word is on the stack
					if (save_ack_i) begin
						d.save_req   = 1'b0;
						d.mask       = q.pmask;
						d.fetch_addr = calc_addr;
						d.fetch_req  = 1'b1;
						d.st         = evr_pkg::ST_FVEC;
					end
				end
				evr_pkg::ST_FVEC: begin
					if (fetch_ack_i) begin
						d.pc        = fetch_data_i;
						d.fetch_req = 1'b0;
						d.jump      = 1'b1;
						d.st        = evr_pkg::ST_RUN;
					end
				end
			endcase
		end
	end

	// power-up waits in reset for a full-hold pulse on either pin, cold or warm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q         <= '0;
			q.st      <= evr_pkg::ST_RESET;
			q.cpu_rst <= 1'b1;
			q.per_rst <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o      = q.wb_dat;
	assign wb_ack_o      = q.wb_ack;
	assign exc_ack_o     = q.exc_ack;
	assign exc_rej_o     = q.exc_rej;
	assign save_req_o    = q.save_req;
	assign fetch_req_o   = q.fetch_req;
	assign fetch_addr_o  = q.fetch_addr;
	assign pc_o          = q.pc;
	assign sp_o          = q.sp;
	assign jump_o        = q.jump;
	assign sp_load_o     = q.sp_load;
	assign mask_o        = q.mask;
	assign vector_base_o = q.vbase;
	assign cpu_rst_o     = q.cpu_rst;
	assign per_rst_o     = q.per_rst;

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_pc_fetched;
		q.st == evr_pkg::ST_FPC && fetch_ack_i;
	endsequence
	sequence s_sp_fetched;
		q.st == evr_pkg::ST_FSP && fetch_ack_i;
	endsequence
	sequence s_vec_fetched;
		q.st == evr_pkg::ST_FVEC && fetch_ack_i;
	endsequence
	a_reset_pc_addr: assert property (
		q.st == evr_pkg::ST_FPC |-> q.fetch_addr == {22'h0, q.vec, 2'h0} &&
			q.vec == (q.warm ? `VEC_WARM_PC : `VEC_COLD_PC))
		else $error("reset counter fetch at wrong address");
	a_sp_follows_pc: assert property (
		s_pc_fetched |=> q.st == evr_pkg::ST_FSP && q.fetch_addr == $past(q.fetch_addr) + 32'h4 &&
			pc_o == $past(fetch_data_i))
		else $error("stack pointer fetch does not follow counter fetch");
	a_reset_init: assert property (
		s_sp_fetched |=> vector_base_o == `VBASE_RESET && mask_o == `MASK_ALL_ONES &&
			jump_o && sp_load_o && !cpu_rst_o && sp_o == $past(fetch_data_i))
		else $error("reset entry did not initialise base, mask and stack pointer");
	a_base_added: assert property (
		$rose(q.st == evr_pkg::ST_FVEC) |-> q.fetch_addr == $past(q.vbase) + {22'h0, q.vec, 2'h0})
		else $error("vector fetch address ignores the base");
	a_save_first: assert property (
		$rose(q.st == evr_pkg::ST_FVEC) |-> $past(q.st == evr_pkg::ST_SAVE && save_ack_i))
		else $error("vector fetched before status was saved");
	a_cold_init: assert property (
		!cold_s |=> cpu_rst_o && per_rst_o && q.st == evr_pkg::ST_RESET)
		else $error("cold pin low without full reset");
	a_warm_no_per: assert property (
		$rose(q.warm) |-> cpu_rst_o && !per_rst_o)
		else $error("warm reset touched the peripherals");
	a_warm_waits_bus: assert property (
		$rose(q.warm) |-> $past(!bus_busy_i))
		else $error("warm reset entered during a bus cycle");
	a_short_hold: assert property (
		q.st == evr_pkg::ST_RESET && cold_s && warm_s && q.cnt != `RESET_HOLD_CYC
			|=> q.st == evr_pkg::ST_RESET [*2])
		else $error("reset released after too short a pulse");
	a_no_reserved: assert property (
		exc_ack_o |-> !vec_reserved(q.vec) && q.st == evr_pkg::ST_SAVE)
		else $error("reserved vector produced");
	a_irq_map: assert property (
		exc_ack_o && $past(exc_kind_i == evr_pkg::EXC_IRQ) |-> q.vec == `VEC_IRQ_BASE + {5'h0, $past(exc_num_i[2:0])})
		else $error("interrupt line mapped to wrong vector");
	a_jump_target: assert property (
		s_vec_fetched |=> jump_o && pc_o == $past(fetch_data_i) && !fetch_req_o)
		else $error("fetched vector not used as target");

endmodule : exception_vector_reset_unit

// ===== shared/evr_pkg.sv
// types shared by the exception vector and reset unit
package evr_pkg;

	typedef enum logic [5:0] {
		ST_RUN   = 6'h01,
		ST_RESET = 6'h02,
		ST_FPC   = 6'h04,
		ST_FSP   = 6'h08,
		ST_SAVE  = 6'h10,
		ST_FVEC  = 6'h20
	} state_t;

	typedef enum logic [3:0] {
		EXC_ILL_GEN  = 4'h0,
		EXC_ILL_SLOT = 4'h1,
		EXC_CPU_AERR = 4'h2,
		EXC_XFR_AERR = 4'h3,
		EXC_NMI      = 4'h4,
		EXC_UBRK     = 4'h5,
		EXC_IRQ      = 4'h6,
		EXC_PERIPH   = 4'h7,
		EXC_TRAP     = 4'h8
	} exc_kind_t;

	typedef struct packed {
		state_t      st;
		logic [31:0] vbase;
		logic [3:0]  mask;
		logic [3:0]  pmask;
		logic [4:0]  cnt;
		logic        warm;
		logic [7:0]  vec;
		logic [31:0] pc;
		logic [31:0] sp;
		logic [31:0] fetch_addr;
		logic [31:0] wb_dat;
		logic        fetch_req;
		logic        save_req;
		logic        jump;
		logic        sp_load;
		logic        exc_ack;
		logic        exc_rej;
		logic        cpu_rst;
		logic        per_rst;
		logic        wb_ack;
	} ctl_t;

	typedef struct packed {
		logic [1:0] s1;
		logic [1:0] s2;
	} sync_t;

endpackage : evr_pkg

// ===== shared/evr_regs.svh
// register offsets, vector numbers and timing counts of the exception vector and reset unit
`ifndef EVR_REGS_SVH
`define EVR_REGS_SVH

`define OFF_VECTOR_BASE 8'h00
`define OFF_STATUS_WORD 8'h04
`define OFF_UNIT_STATE  8'h08
`define OFF_INIT_PC     8'h0c
`define OFF_INIT_SP     8'h10

`define VEC_COLD_PC     8'h00
`define VEC_WARM_PC     8'h02
`define VEC_ILL_GEN     8'h04
`define VEC_RSVD_A      8'h05
`define VEC_ILL_SLOT    8'h06
`define VEC_RSVD_B      8'h07
`define VEC_RSVD_C      8'h08
`define VEC_CPU_AERR    8'h09
`define VEC_XFER_AERR   8'h0a
`define VEC_NMI         8'h0b
`define VEC_UBRK        8'h0c
`define VEC_SYS_LO      8'h0d
`define VEC_SYS_HI      8'h1f
`define VEC_TRAP_LO     8'h20
`define VEC_TRAP_HI     8'h3f
`define VEC_IRQ_BASE    8'h40
`define VEC_PERIPH_LO   8'h48
`define IRQ_LINE_MAX    8'h07

`define RESET_HOLD_CYC  5'h14
`define MASK_ALL_ONES   4'hf
`define VBASE_RESET     32'h0
`define PIN_IDLE        2'h3

`endif
